// ==== pkg/crtc_pkg.sv ====
// Constants, timing counts and carrier types for the bus receive timing core.
package crtc_pkg;

   // ----------------------------------------------------------------
   // Count source
   // ----------------------------------------------------------------
   localparam int unsigned SRC_HZ = 32768; // Nominal count source rate.
   localparam logic [1:0] SRC_SUBCLK = 2'h0; // Sub-clock selected.
   localparam logic [1:0] SRC_TIMER = 2'h1; // Halved timer underflow selected.

   // Converts microseconds to the nearest whole count source cycle.
   function automatic logic [7:0] us_to_ticks(input int unsigned us);
      int unsigned t;
      t = (us * SRC_HZ + 500000) / 1000000;
      if (t < 1)
      begin
         t = 1;
      end
      return t[7:0];
   endfunction

   // ----------------------------------------------------------------
   // Bus timing in microseconds
   // ----------------------------------------------------------------
   localparam int unsigned ST_LOW_MIN_US = 3500; // Start low, narrow range.
   localparam int unsigned ST_LOW_MAX_US = 3900;
   localparam int unsigned ST_PER_MIN_US = 4300; // Start period, narrow range.
   localparam int unsigned ST_PER_MAX_US = 4700;
   localparam int unsigned WIDEN_US = 100; // Extra margin of the wide ranges.
   localparam int unsigned D1_LOW_MIN_US = 400; // Data 1 low period.
   localparam int unsigned D1_LOW_MAX_US = 800;
   localparam int unsigned D0_LOW_MIN_US = 1300; // Data 0 low period.
   localparam int unsigned D0_LOW_MAX_US = 1700;
   localparam int unsigned D_PER_MIN_US = 2050; // Data bit period.
   localparam int unsigned D_PER_MAX_US = 2750;
   localparam int unsigned DECIDE_US = 1050; // Data 1 / data 0 decision point.
   localparam int unsigned ACK_LOW_US = 1500; // Low time of a driven ACK.
   localparam int unsigned ERR_LOW_US = 3600; // Error low pulse length.

   // ----------------------------------------------------------------
   // Frame layout
   // ----------------------------------------------------------------
   localparam logic [3:0] BIT_LAST_DATA = 4'h7; // Eighth data bit index.
   localparam logic [3:0] BIT_EOM = 4'h8; // End-of-message bit index.
   localparam logic [3:0] BIT_ACK = 4'h9; // Tenth bit index.

   // Software settings, sampled on count ticks.
   typedef struct packed {
      logic interface_enable_bit;
      logic receive_enable_bit;
      logic filter_enable_bit;
      logic detect_timing_select;
      logic start_range_select;
      logic data_range_select;
      logic error_pulse_enable;
      logic error_pulse_timing_select;
      logic ack_source_select;
      logic software_ack_output_bit;
      logic [15:0] own_address_select; // High byte: 1000b..1111b, low: 0000b..0111b.
   } crtc_cfg_s;

   // Received block results.
   typedef struct packed {
      logic [7:0] data;
      logic eom;
      logic ack_in;
   } crtc_rx_s;

   // Receiver states, one-hot.
   typedef enum logic [6:0] {
      ST_IDLE = 7'h01,
      ST_START_LOW = 7'h02,
      ST_START_HIGH = 7'h04,
      ST_BIT_LOW = 7'h08,
      ST_BIT_HIGH = 7'h10,
      ST_ERR_WAIT = 7'h20,
      ST_ERR_PULSE = 7'h40
   } crtc_state_e;

endpackage

// ==== src/crtc_core.sv ====
// Receive side and bit timing of the single-wire control bus interface.
`timescale 1ns/1ps
`default_nettype none
module crtc_core (
   // Clock and reset
   input wire logic core_clk,
   input wire logic rst,
   // Count source inputs
   input wire logic [1:0] count_source_select,
   input wire logic sub_clock,
   input wire logic timer_underflow,
   // Software settings
   input wire crtc_pkg::crtc_cfg_s cfg,
   // Bus pin
   input wire logic bus_in,
   output logic bus_out,
   output logic bus_oe,
   // Status
   output logic receiving_flag,
   output logic start_detected_flag,
   output logic receive_error_flag,
   output logic eighth_bit_received_flag,
   output crtc_pkg::crtc_rx_s rx
);

   // ----------------------------------------------------------------
   // Timing counts in count source cycles
   // ----------------------------------------------------------------
   localparam logic [7:0] ST_LOW_MIN = crtc_pkg::us_to_ticks(crtc_pkg::ST_LOW_MIN_US);
   localparam logic [7:0] ST_LOW_MAX = crtc_pkg::us_to_ticks(crtc_pkg::ST_LOW_MAX_US);
   localparam logic [7:0] ST_PER_MIN = crtc_pkg::us_to_ticks(crtc_pkg::ST_PER_MIN_US);
   localparam logic [7:0] ST_PER_MAX = crtc_pkg::us_to_ticks(crtc_pkg::ST_PER_MAX_US);
   localparam logic [7:0] WIDEN = crtc_pkg::us_to_ticks(crtc_pkg::WIDEN_US);
   localparam logic [7:0] D1_LOW_MIN = crtc_pkg::us_to_ticks(crtc_pkg::D1_LOW_MIN_US);
   localparam logic [7:0] D1_LOW_MAX = crtc_pkg::us_to_ticks(crtc_pkg::D1_LOW_MAX_US);
   localparam logic [7:0] D0_LOW_MIN = crtc_pkg::us_to_ticks(crtc_pkg::D0_LOW_MIN_US);
   localparam logic [7:0] D0_LOW_MAX = crtc_pkg::us_to_ticks(crtc_pkg::D0_LOW_MAX_US);
   localparam logic [7:0] D_PER_MIN = crtc_pkg::us_to_ticks(crtc_pkg::D_PER_MIN_US);
   localparam logic [7:0] D_PER_MAX = crtc_pkg::us_to_ticks(crtc_pkg::D_PER_MAX_US);
   localparam logic [7:0] DECIDE = crtc_pkg::us_to_ticks(crtc_pkg::DECIDE_US);
   localparam logic [7:0] ACK_LOW = crtc_pkg::us_to_ticks(crtc_pkg::ACK_LOW_US);
   localparam logic [7:0] ERR_LOW = crtc_pkg::us_to_ticks(crtc_pkg::ERR_LOW_US);

   // True when value lies in [lo, hi], widened on both ends when wide is set.
   function automatic logic in_window(input logic [7:0] v, input logic [7:0] lo, input logic [7:0] hi,
                                      input logic wide);
      logic [8:0] l;
      logic [8:0] h;
      l = wide ? ({1'b0, lo} - {1'b0, WIDEN}) : {1'b0, lo};
      h = wide ? ({1'b0, hi} + {1'b0, WIDEN}) : {1'b0, hi};
      return ({1'b0, v} >= l) && ({1'b0, v} <= h);
   endfunction

   // ----------------------------------------------------------------
   // Count source tick generation
   // ----------------------------------------------------------------
   logic sc_meta_r; // First stage, read only by the second.
   logic sc_sync_r; // Synchronised sub-clock.
   logic sc_prev_r; // Previous synchronised level for edge detection.
   logic tmr_tog_r; // Toggles on each timer underflow.
   logic tmr_prev_r; // Previous toggle level.
   logic tmr_tog_nxt;
   logic tick; // One core cycle per count source period.

   // Timer source toggles on every underflow, two underflows per period.
   always_comb
   begin
      tmr_tog_nxt = tmr_tog_r ^ timer_underflow;
   end

   // Registers the source sampling stages.
   always_ff @(posedge core_clk or posedge rst)
   begin
      if (rst)
      begin
         sc_meta_r <= 1'b0;
         sc_sync_r <= 1'b0;
         sc_prev_r <= 1'b0;
         tmr_tog_r <= 1'b0;
         tmr_prev_r <= 1'b0;
      end
      else
      begin
         sc_meta_r <= sub_clock;
         sc_sync_r <= sc_meta_r;
         sc_prev_r <= sc_sync_r;
         tmr_tog_r <= tmr_tog_nxt;
         tmr_prev_r <= tmr_tog_r;
      end
   end

   // Rising edge of the selected source marks one count source cycle.
   always_comb
   begin
      case (count_source_select)
         crtc_pkg::SRC_SUBCLK: tick = sc_sync_r & ~sc_prev_r;
         crtc_pkg::SRC_TIMER: tick = tmr_tog_r & ~tmr_prev_r;
         default: tick = 1'b0;
      endcase
   end

   // ----------------------------------------------------------------
   // Settings taken on ticks, and input filter
   // ----------------------------------------------------------------
   crtc_pkg::crtc_cfg_s cfg_r; // Settings as seen by the logic.
   crtc_pkg::crtc_cfg_s cfg_nxt;
   logic smp_r; // Pin level sampled on the last tick.
   logic line_r; // Level passed inward.
   logic line_prev_r; // Inward level one tick earlier.
   logic smp_nxt;
   logic line_nxt;
   logic line_prev_nxt;

   // Latches settings and samples the pin once per tick.
   always_comb
   begin
      cfg_nxt = cfg_r;
      smp_nxt = smp_r;
      line_nxt = line_r;
      line_prev_nxt = line_prev_r;
      if (tick)
      begin
         cfg_nxt = cfg;
         smp_nxt = bus_in;
         line_prev_nxt = line_r;
         // With the filter on, a level is passed only when seen twice in a row.
         if (!cfg_r.filter_enable_bit || (bus_in == smp_r))
         begin
            line_nxt = bus_in;
         end
      end
   end

   // Registers settings and filter state; the idle line reads high.
   always_ff @(posedge core_clk or posedge rst)
   begin
      if (rst)
      begin
         cfg_r <= '0;
         smp_r <= 1'b1;
         line_r <= 1'b1;
         line_prev_r <= 1'b1;
      end
      else
      begin
         cfg_r <= cfg_nxt;
         smp_r <= smp_nxt;
         line_r <= line_nxt;
         line_prev_r <= line_prev_nxt;
      end
   end

   // ----------------------------------------------------------------
   // Receiver state machine
   // ----------------------------------------------------------------
   crtc_pkg::crtc_state_e state_r, state_nxt; // Receiver state.
   logic [7:0] low_cnt_r, low_cnt_nxt; // Ticks of the current low period.
   logic [7:0] per_cnt_r, per_cnt_nxt; // Ticks since the bit's falling edge.
   logic [3:0] bit_idx_r, bit_idx_nxt; // Bit position within the block.
   logic [7:0] shift_r, shift_nxt; // Incoming data bits.
   logic header_r, header_nxt; // Current block is the header.
   logic [3:0] dest_r, dest_nxt; // Destination address of the frame.
   logic drive_r, drive_nxt; // Pulls the bus low.
   logic st_flag_r, st_flag_nxt;
   logic err_flag_r, err_flag_nxt;
   logic b8_flag_r, b8_flag_nxt;
   crtc_pkg::crtc_rx_s rx_r, rx_nxt;
   logic fall; // Falling edge of inward level on this tick.
   logic rise; // Rising edge of inward level on this tick.
   logic bit_val; // Decoded value of the bit ending now.
   logic bit_ok; // Low period inside the data window.
   logic ack_low; // This device answers ACK.
   logic rx_on; // Receiving allowed.
   logic [7:0] low_inc;
   logic [7:0] per_inc;

   assign fall = tick & line_prev_r & ~line_r;
   assign rise = tick & ~line_prev_r & line_r;
   assign rx_on = cfg_r.interface_enable_bit & cfg_r.receive_enable_bit;
   assign low_inc = (low_cnt_r == 8'hff) ? low_cnt_r : low_cnt_r + 8'h01;
   assign per_inc = (per_cnt_r == 8'hff) ? per_cnt_r : per_cnt_r + 8'h01;

   // Decodes the bit from its low time and judges its window.
   always_comb
   begin
      bit_ok = in_window(low_cnt_r, D1_LOW_MIN, D1_LOW_MAX, cfg_r.data_range_select) ||
               in_window(low_cnt_r, D0_LOW_MIN, D0_LOW_MAX, cfg_r.data_range_select);
      if (!cfg_r.detect_timing_select)
      begin
         bit_val = (low_cnt_r < DECIDE);
      end
      else
      begin
         bit_val = in_window(low_cnt_r, D1_LOW_MIN, D1_LOW_MAX, cfg_r.data_range_select);
      end
   end

   // Selects the ACK answer for the tenth bit; low output means ACK.
   always_comb
   begin
      if (!cfg_r.ack_source_select)
      begin
         ack_low = ~cfg_r.software_ack_output_bit;
      end
      else
      begin
         ack_low = cfg_r.own_address_select[dest_r];
      end
   end

   // Computes next receiver state, counters, flags and data.
   always_comb
   begin
      state_nxt = state_r;
      low_cnt_nxt = low_cnt_r;
      per_cnt_nxt = per_cnt_r;
      bit_idx_nxt = bit_idx_r;
      shift_nxt = shift_r;
      header_nxt = header_r;
      dest_nxt = dest_r;
      drive_nxt = drive_r;
      rx_nxt = rx_r;
      st_flag_nxt = st_flag_r;
      b8_flag_nxt = b8_flag_r;
      // Error flag holds only while reception stays enabled; a new error wins.
      err_flag_nxt = err_flag_r & cfg_r.receive_enable_bit;
      if (tick)
      begin
         low_cnt_nxt = line_r ? 8'h00 : low_inc;
         per_cnt_nxt = per_inc;
         case (state_r)
            crtc_pkg::ST_IDLE:
            begin
               drive_nxt = 1'b0;
               if (fall && rx_on)
               begin
                  state_nxt = crtc_pkg::ST_START_LOW;
                  per_cnt_nxt = 8'h00;
                  low_cnt_nxt = 8'h00;
               end
            end
            crtc_pkg::ST_START_LOW:
            begin
               // A start bit out of range is dropped quietly, with no error pulse.
               if (rise)
               begin
                  state_nxt = in_window(low_cnt_r, ST_LOW_MIN, ST_LOW_MAX, cfg_r.start_range_select) ?
                              crtc_pkg::ST_START_HIGH : crtc_pkg::ST_IDLE;
               end
               else if (low_cnt_r > ST_PER_MAX)
               begin
                  state_nxt = crtc_pkg::ST_IDLE;
               end
            end
            crtc_pkg::ST_START_HIGH:
            begin
               if (fall)
               begin
                  if (in_window(per_cnt_r, ST_PER_MIN, ST_PER_MAX, cfg_r.start_range_select))
                  begin
                     st_flag_nxt = 1'b1;
                     header_nxt = 1'b1;
                     bit_idx_nxt = 4'h0;
                     per_cnt_nxt = 8'h00;
                     low_cnt_nxt = 8'h00;
                     state_nxt = crtc_pkg::ST_BIT_LOW;
                  end
                  else
                  begin
                     state_nxt = crtc_pkg::ST_START_LOW;
                     per_cnt_nxt = 8'h00;
                     low_cnt_nxt = 8'h00;
                  end
               end
               else if (per_cnt_r > ST_PER_MAX)
               begin
                  state_nxt = crtc_pkg::ST_IDLE;
               end
            end
            crtc_pkg::ST_BIT_LOW:
            begin
               // ACK low is held for the data 0 time, then released.
               if (drive_r && low_cnt_r >= ACK_LOW - 8'h01)
               begin
                  drive_nxt = 1'b0;
               end
               if (rise)
               begin
                  if (!bit_ok)
                  begin
                     err_flag_nxt = 1'b1;
                     state_nxt = crtc_pkg::ST_ERR_WAIT;
                  end
                  else
                  begin
                     state_nxt = crtc_pkg::ST_BIT_HIGH;
                     if (bit_idx_r <= crtc_pkg::BIT_LAST_DATA)
                     begin
                        shift_nxt = {shift_r[6:0], bit_val};
                     end
                     if (bit_idx_r == crtc_pkg::BIT_LAST_DATA)
                     begin
                        rx_nxt.data = {shift_r[6:0], bit_val};
                        b8_flag_nxt = 1'b1;
                        st_flag_nxt = 1'b0;
                        if (header_r)
                        begin
                           dest_nxt = {shift_r[2:0], bit_val};
                        end
                     end
                     if (bit_idx_r == crtc_pkg::BIT_EOM)
                     begin
                        rx_nxt.eom = bit_val;
                     end
                     if (bit_idx_r == crtc_pkg::BIT_ACK)
                     begin
                        rx_nxt.ack_in = bit_val;
                        b8_flag_nxt = 1'b0;
                     end
                  end
               end
               else if (low_cnt_r > D_PER_MAX)
               begin
                  err_flag_nxt = 1'b1;
                  state_nxt = crtc_pkg::ST_ERR_WAIT;
               end
            end
            crtc_pkg::ST_BIT_HIGH:
            begin
               if (fall)
               begin
                  if (!in_window(per_cnt_r, D_PER_MIN, D_PER_MAX, cfg_r.data_range_select))
                  begin
                     err_flag_nxt = 1'b1;
                     state_nxt = crtc_pkg::ST_ERR_WAIT;
                  end
                  else
                  begin
                     per_cnt_nxt = 8'h00;
                     low_cnt_nxt = 8'h00;
                     state_nxt = crtc_pkg::ST_BIT_LOW;
                     if (bit_idx_r == crtc_pkg::BIT_ACK)
                     begin
                        bit_idx_nxt = 4'h0;
                        header_nxt = 1'b0;
                     end
                     else
                     begin
                        bit_idx_nxt = bit_idx_r + 4'h1;
                     end
                     // The tenth bit is pulled low at the initiator's falling edge.
                     if (bit_idx_r == crtc_pkg::BIT_EOM && ack_low)
                     begin
                        drive_nxt = 1'b1;
                     end
                  end
               end
               else if (per_cnt_r > D_PER_MAX)
               begin
                  // Bus idle after a bit: end of message or a broken frame.
                  state_nxt = crtc_pkg::ST_IDLE;
               end
            end
            crtc_pkg::ST_ERR_WAIT:
            begin
               drive_nxt = 1'b0;
               // Timing select 1 waits for the line to be released first.
               if (cfg_r.error_pulse_enable && (!cfg_r.error_pulse_timing_select || line_r))
               begin
                  drive_nxt = 1'b1;
                  low_cnt_nxt = 8'h00;
                  state_nxt = crtc_pkg::ST_ERR_PULSE;
               end
               else if (!cfg_r.receive_enable_bit)
               begin
                  state_nxt = crtc_pkg::ST_IDLE;
               end
            end
            crtc_pkg::ST_ERR_PULSE:
            begin
               // Pulse length counted in ticks while this device holds the line.
               low_cnt_nxt = low_inc;
               if (low_cnt_r >= ERR_LOW - 8'h01)
               begin
                  drive_nxt = 1'b0;
                  state_nxt = crtc_pkg::ST_ERR_WAIT;
                  if (cfg_r.receive_enable_bit)
                  begin
                     state_nxt = crtc_pkg::ST_IDLE;
                  end
               end
            end
            default:
            begin
               state_nxt = crtc_pkg::ST_IDLE;
               drive_nxt = 1'b0;
            end
         endcase
         // Disabling reception abandons the frame and releases the bus, except during an error pulse.
         if (!rx_on && state_r != crtc_pkg::ST_ERR_PULSE)
         begin
            state_nxt = crtc_pkg::ST_IDLE;
            drive_nxt = 1'b0;
            b8_flag_nxt = 1'b0;
            st_flag_nxt = 1'b0;
         end
      end
   end

   // Registers receiver state.
   always_ff @(posedge core_clk or posedge rst)
   begin
      if (rst)
      begin
         state_r <= crtc_pkg::ST_IDLE;
         low_cnt_r <= 8'h00;
         per_cnt_r <= 8'h00;
         bit_idx_r <= 4'h0;
         shift_r <= 8'h00;
         header_r <= 1'b0;
         dest_r <= 4'h0;
         drive_r <= 1'b0;
         st_flag_r <= 1'b0;
         err_flag_r <= 1'b0;
         b8_flag_r <= 1'b0;
         rx_r <= '0;
      end
      else
      begin
         state_r <= state_nxt;
         low_cnt_r <= low_cnt_nxt;
         per_cnt_r <= per_cnt_nxt;
         bit_idx_r <= bit_idx_nxt;
         shift_r <= shift_nxt;
         header_r <= header_nxt;
         dest_r <= dest_nxt;
         drive_r <= drive_nxt;
         st_flag_r <= st_flag_nxt;
         err_flag_r <= err_flag_nxt;
         b8_flag_r <= b8_flag_nxt;
         rx_r <= rx_nxt;
      end
   end

   // ----------------------------------------------------------------
   // Outputs
   // ----------------------------------------------------------------
   // The pin is only ever pulled low; high comes from the bus pull-up.
   assign bus_out = 1'b0;
   assign bus_oe = drive_r;
   assign receiving_flag = (state_r != crtc_pkg::ST_IDLE);
   assign start_detected_flag = st_flag_r;
   assign receive_error_flag = err_flag_r;
   assign eighth_bit_received_flag = b8_flag_r;
   assign rx = rx_r;

endmodule
`default_nettype wire

// ==== verification/crtc_props.sv ====
// Port checker for the receive timing core.
`timescale 1ns/1ps
`default_nettype none
module crtc_props (
   // Clock, reset and count source
   input wire logic core_clk,
   input wire logic rst,
   input wire logic timer_underflow,
   // Settings and bus
   input wire crtc_pkg::crtc_cfg_s cfg,
   input wire logic bus_out,
   input wire logic bus_oe,
   // Status
   input wire logic receiving_flag,
   input wire logic receive_error_flag,
   input wire logic eighth_bit_received_flag
);
   logic ph_r;
   logic ph_nxt;
   logic tk;
   // Every second underflow pulse is a count tick.
   always_comb ph_nxt = ph_r ^ timer_underflow;
   assign tk = timer_underflow & ~ph_r;
   always_ff @(posedge core_clk or posedge rst)
      if (rst) ph_r <= 1'b0;
      else ph_r <= ph_nxt;
   default clocking @(posedge core_clk); endclocking
   default disable iff (rst);
   sequence s_tick_back;
      $past(tk, 1) || $past(tk, 2) || $past(tk, 3) || $past(tk, 4);
   endsequence
   property p_pull_only; bus_out == 1'b0; endproperty
   a_pull_only: assert property (p_pull_only) else $error("bus driven high");
   property p_err_clear; $fell(receive_error_flag) |-> !cfg.receive_enable_bit; endproperty
   a_err_clear: assert property (p_err_clear) else $error("error flag cleared while enabled");
   property p_eighth_ctx; $rose(eighth_bit_received_flag) |-> receiving_flag && !receive_error_flag; endproperty
   a_eighth_ctx: assert property (p_eighth_ctx) else $error("eighth flag outside a reception");
   property p_err_ctx; $rose(receive_error_flag) |-> receiving_flag; endproperty
   a_err_ctx: assert property (p_err_ctx) else $error("error flag while idle");
   property p_oe_enabled; $rose(bus_oe) |-> cfg.interface_enable_bit && cfg.receive_enable_bit; endproperty
   a_oe_enabled: assert property (p_oe_enabled) else $error("bus pulled while disabled");
   property p_oe_on_tick; $changed(bus_oe) |-> s_tick_back; endproperty
   a_oe_on_tick: assert property (p_oe_on_tick) else $error("bus enable moved off a tick");
   property p_flag_on_tick; $changed(eighth_bit_received_flag) |-> s_tick_back; endproperty
   a_flag_on_tick: assert property (p_flag_on_tick) else $error("flag moved off a tick");
   property p_err_pulse; $rose(bus_oe) && receive_error_flag |-> bus_oe [*8]; endproperty
   a_err_pulse: assert property (p_err_pulse) else $error("error pulse too short");
endmodule
`default_nettype wire

// ==== verification/crtc_node.sv ====
// Model of another node that sends frames on the shared wire.
`timescale 1ns/1ps
`default_nettype none
module crtc_node (
   // Clock and count source
   input wire logic core_clk,
   input wire logic uf,
   // Wire pull
   output logic pull_low
);
   initial pull_low = 1'b0;
   // Waits n ticks of two underflows each, ending at a falling edge.
   task automatic wait_ticks(input int n);
      repeat (2 * n) @(posedge core_clk iff uf);
      @(negedge core_clk);
   endtask
   // Sends one bit: low for lo ticks, then released to the end of per.
   task automatic send(input int lo, input int per);
      pull_low = 1'b1;
      wait_ticks(lo);
      pull_low = 1'b0;
      wait_ticks(per - lo);
   endtask
endmodule
`default_nettype wire

// ==== verification/crtc_core_tb.sv ====
// Self-checking bench for the receive timing core.
`timescale 1ns/1ps
`default_nettype none
module crtc_core_tb;
   logic core_clk = 1'b0;
   logic rst = 1'b1;
   logic timer_underflow = 1'b0;
   logic [1:0] cnt = 2'h0;
   crtc_pkg::crtc_cfg_s cfg = '0;
   logic node_low, bus_in, bus_out, bus_oe, receiving_flag, start_detected_flag;
   logic receive_error_flag, eighth_bit_received_flag;
   crtc_pkg::crtc_rx_s rx;
   int errors = 0;
   int comparisons = 0;
   always #5 core_clk = ~core_clk;
   // Underflow every fourth cycle, so one tick every eighth.
   always @(negedge core_clk)
   begin
      cnt <= cnt + 2'h1;
      timer_underflow <= (cnt == 2'h3);
   end
   assign bus_in = ~(node_low | bus_oe);
   crtc_node node (.core_clk(core_clk), .uf(timer_underflow), .pull_low(node_low));
   crtc_core uut (.core_clk(core_clk), .rst(rst), .count_source_select(crtc_pkg::SRC_TIMER), .sub_clock(1'b0),
      .timer_underflow(timer_underflow), .cfg(cfg), .bus_in(bus_in), .bus_out(bus_out), .bus_oe(bus_oe),
      .receiving_flag(receiving_flag), .start_detected_flag(start_detected_flag),
      .receive_error_flag(receive_error_flag), .eighth_bit_received_flag(eighth_bit_received_flag), .rx(rx));
   task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
      comparisons++;
      if (seen !== exp)
      begin
         errors++;
         $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic tally_and_finish();
      $display("errors %0d comparisons %0d", errors, comparisons);
      if (errors == 0 && comparisons > 0)
         $display("ALL CHECKS OK");
      else
         $display("CHECKS NOT OK");
      $finish;
   endtask
   // Sends one block and checks data, flags and the ACK slot answer.
   task automatic frame(input logic [7:0] b, input logic ack);
      node.send(121, 148);
      for (int i = 7; i >= 0; i--)
      begin
         node.send(b[i] ? 18 : 49, 75);
         if (i == 6) chk(start_detected_flag, 8'h01);
      end
      chk(rx.data, b);
      chk(eighth_bit_received_flag, 8'h01);
      chk(start_detected_flag, 8'h00);
      node.send(18, 75);
      node.send(18, 30);
      chk(bus_oe, ack);
      node.wait_ticks(145);
      chk(eighth_bit_received_flag, 8'h00);
      chk(rx.eom, 8'h01);
      chk(rx.ack_in, {7'h00, ~ack});
      chk(receiving_flag, 8'h00);
   endtask
   initial
   begin
      repeat (12) @(negedge core_clk);
      rst = 1'b0;
      chk(bus_oe, 8'h00);
      cfg.interface_enable_bit = 1'b1;
      cfg.receive_enable_bit = 1'b1;
      cfg.ack_source_select = 1'b1;
      cfg.own_address_select = 16'h0010;
      node.wait_ticks(5);
      frame(8'h14, 1'b1);
      frame(8'h13, 1'b0);
      cfg.own_address_select = 16'h8010;
      frame(8'h4f, 1'b1);
      cfg.own_address_select = 16'h0010;
      cfg.filter_enable_bit = 1'b1;
      cfg.start_range_select = 1'b1;
      cfg.data_range_select = 1'b1;
      cfg.detect_timing_select = 1'b1;
      frame(8'h4f, 1'b0);
      cfg.ack_source_select = 1'b0;
      frame(8'h4f, 1'b1);
      cfg.software_ack_output_bit = 1'b1;
      cfg.error_pulse_enable = 1'b1;
      cfg.error_pulse_timing_select = 1'b1;
      node.send(60, 148);
      chk(bus_oe, 8'h00);
      node.send(121, 148);
      node.send(100, 100);
      chk(receive_error_flag, 8'h01);
      node.wait_ticks(100);
      chk(bus_oe, 8'h01);
      node.wait_ticks(30);
      chk(bus_oe, 8'h00);
      cfg.receive_enable_bit = 1'b0;
      node.wait_ticks(3);
      chk(receive_error_flag, 8'h00);
      cfg.receive_enable_bit = 1'b1;
      node.wait_ticks(5);
      frame(8'h14, 1'b0);
      tally_and_finish();
   end
   initial
   begin
      #900us;
      errors++;
      tally_and_finish();
   end
endmodule
bind crtc_core crtc_props u_props (.core_clk(core_clk), .rst(rst), .timer_underflow(timer_underflow), .cfg(cfg),
   .bus_out(bus_out), .bus_oe(bus_oe), .receiving_flag(receiving_flag), .receive_error_flag(receive_error_flag),
   .eighth_bit_received_flag(eighth_bit_received_flag));
`default_nettype wire
